// file: logic/spp_pkg.sv
// Shared constants and types for the strobed parallel port
`default_nettype none
package spp_pkg;

  // Direct addresses on the special-function bus
  localparam logic [7:0] ADDR_LATCH = 8'hd8;
  localparam logic [7:0] ADDR_CTL = 8'he8;

  // Reset values
  localparam logic [7:0] CTL_RST = 8'hfc;
  localparam logic [7:0] LATCH_RST = 8'hff;
  localparam logic [7:0] IBUF_RST = 8'hff;

  // Control/status field positions
  localparam int unsigned BIT_IN_FULL = 0;
  localparam int unsigned BIT_OUT_FULL = 1;
  localparam int unsigned BIT_IN_STROBE_MODE = 2;
  localparam int unsigned BIT_OUT_CLEAR_EDGE = 3;
  localparam int unsigned BIT_OUT_PIN_MODE_LO = 4;
  localparam int unsigned BIT_OUT_PIN_MODE_HI = 5;
  localparam int unsigned BIT_IN_PIN_MODE_LO = 6;
  localparam int unsigned BIT_IN_PIN_MODE_HI = 7;
  localparam logic [7:0] CTL_RO_MASK = 8'h03;
  localparam logic [2:0] FIRST_RW_BIT = 3'h2;

  // Data path sizes
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FIFO_DEPTH = 8;

  // Synchroniser reset: strobes idle high, flag pins low
  localparam logic [3:0] CTL_PINS_RST = 4'hc;

  // Flag pin function
  typedef enum logic [1:0] {
    PIN_DRIVE0 = 2'b00,
    PIN_DRIVE1 = 2'b01,
    PIN_FLAG = 2'b10,
    PIN_INPUT = 2'b11
  } spp_pin_mode_t;

  typedef struct packed {
    spp_pin_mode_t in_side_pin_mode;
    spp_pin_mode_t out_side_pin_mode;
    logic out_clear_edge_mode;
    logic in_strobe_mode;
    logic out_buffer_full;
    logic in_buffer_full;
  } spp_ctl_t;

  // Special-function bus request
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic bit_op;
    logic [7:0] wdata;
  } spp_sfr_req_t;

  // Control pins as one group
  typedef struct packed {
    logic out_strobe_n;
    logic in_strobe_n;
    logic sel;
    logic gate;
  } spp_ctl_pins_t;

endpackage
`default_nettype wire

// file: logic/spp_sync.sv
// Two-stage synchroniser, parameterised width
`timescale 1ns/100ps
`default_nettype none
module spp_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Data
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= RST_VAL;
      q_out <= RST_VAL;
    end else begin
      meta_r <= d_in;
      q_out <= meta_r;
    end
  end

endmodule // spp_sync
`default_nettype wire

// file: logic/spp_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module spp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  wire logic full;
  wire logic empty;
  wire logic push;
  wire logic pop;

  assign empty = (wr_ptr_r == rd_ptr_r);
  assign full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign push = in_valid && !full;
  assign pop = out_ready && !empty;
  assign out_data = mem[rd_ptr_r[AW-1:0]];

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end

endmodule // spp_fifo
`default_nettype wire

// file: logic/spp_port.sv
// Strobed parallel port: latch, input buffer, control/status and flag pins
//
// Notes on behaviour
// - Pins drive only while the output strobe is low, unless output-always mode is set.
// - A CPU write to the port latch sets the output full flag.
// - Output full clears on the strobe rising edge in clear-edge mode 1, falling edge in 0.
// - Input full sets when the input strobe captures data and clears when the CPU reads it.
// - In input strobe mode 0 the strobe rising edge queues data; the buffer loads it and sets input full when input full is clear.
// - In mode 1 a strobe fall sets input full and the buffer follows pins while low.
// - Output-side pin mode 00 drives 0, 01 drives 1, 10 shows output full, 11 is select input.
// - In select mode, select low puts the port latch on the port, high the control/status.
// - Input-side pin mode 00 drives 0, 01 drives 1, 10 shows input full, 11 is enable input.
// - In port-enable mode a high enable floats the drivers and ignores both strobes.
// - Reset sets control/status bits 2 to 7 and clears bits 0 and 1.
// - All control/status bits are CPU read/write except the full flags, which ignore writes.
// - The port latch is a standard bit-addressable port latch at direct address D8.
// - Control/status sits at direct address E8 with its bits addressable from E8 to EF.
// - With all control pins grounded the port is a quasi-bidirectional port after reset.
`timescale 1ns/100ps
`default_nettype none
module spp_port (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Special-function bus
  input wire spp_pkg::spp_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  // Driver control selection
  input wire logic out_always_mode,
  // Port data pins
  input wire logic [7:0] port_in,
  output logic [7:0] port_out,
  output logic [7:0] port_oe,
  // Strobes from the host
  input wire logic out_strobe_n,
  input wire logic in_strobe_n,
  // Output-side flag pin
  input wire logic out_side_flag_pin_i,
  output logic out_side_flag_pin_o,
  output logic out_side_flag_pin_oe,
  // Input-side flag pin
  input wire logic in_side_flag_pin_i,
  output logic in_side_flag_pin_o,
  output logic in_side_flag_pin_oe,
  // Capture queue status
  output logic in_fifo_ready
);

  // Registers
  spp_pkg::spp_ctl_t ctl_r;
  spp_pkg::spp_ctl_t ctl_nxt;
  logic [7:0] latch_r;
  logic [7:0] latch_nxt;
  logic [7:0] ibuf_r;
  logic [7:0] ibuf_nxt;
  logic ostb_q_r;
  logic istb_q_r;

  // Synchronised pins
  spp_pkg::spp_ctl_pins_t pins_raw;
  spp_pkg::spp_ctl_pins_t pins_s;
  logic [7:0] port_s;

  assign pins_raw.out_strobe_n = out_strobe_n;
  assign pins_raw.in_strobe_n = in_strobe_n;
  assign pins_raw.sel = out_side_flag_pin_i;
  assign pins_raw.gate = in_side_flag_pin_i;

  spp_sync #(
    .WIDTH(4),
    .RST_VAL(spp_pkg::CTL_PINS_RST)
  ) u_sync_ctl (
    .clock(clock),
    .reset_n(reset_n),
    .d_in(pins_raw),
    .q_out(pins_s)
  );

  spp_sync #(
    .WIDTH(spp_pkg::DATA_W),
    .RST_VAL(spp_pkg::IBUF_RST)
  ) u_sync_data (
    .clock(clock),
    .reset_n(reset_n),
    .d_in(port_in),
    .q_out(port_s)
  );

  // Bus decode
  wire logic byte_latch;
  wire logic byte_ctl;
  wire logic bit_latch;
  wire logic bit_ctl;
  wire logic [2:0] bit_idx;
  wire logic wr_latch;
  wire logic wr_ctl;
  wire logic rd_latch;
  wire logic rd_ctl;

  assign bit_idx = sfr_req.addr[2:0];
  assign byte_latch = !sfr_req.bit_op && (sfr_req.addr == spp_pkg::ADDR_LATCH);
  assign byte_ctl = !sfr_req.bit_op && (sfr_req.addr == spp_pkg::ADDR_CTL);
  assign bit_latch = sfr_req.bit_op && (sfr_req.addr[7:3] == spp_pkg::ADDR_LATCH[7:3]);
  assign bit_ctl = sfr_req.bit_op && (sfr_req.addr[7:3] == spp_pkg::ADDR_CTL[7:3]);
  assign wr_latch = sfr_req.wr && (byte_latch || bit_latch);
  assign wr_ctl = sfr_req.wr && (byte_ctl || bit_ctl);
  assign rd_latch = sfr_req.rd && (byte_latch || bit_latch);
  assign rd_ctl = sfr_req.rd && (byte_ctl || bit_ctl);
  assign sfr_hit = byte_latch || byte_ctl || bit_latch || bit_ctl;

  // Port enable gating
  wire logic gate_mode;
  wire logic port_enabled;
  wire logic sel_mode;

  assign gate_mode = (ctl_r.in_side_pin_mode == spp_pkg::PIN_INPUT);
  assign port_enabled = !(gate_mode && pins_s.gate);
  assign sel_mode = (ctl_r.out_side_pin_mode == spp_pkg::PIN_INPUT);

  // Strobe edges, ignored while the port is disabled
  wire logic ostb_rise;
  wire logic ostb_fall;
  wire logic istb_rise;
  wire logic istb_fall;

  assign ostb_rise = port_enabled && pins_s.out_strobe_n && !ostb_q_r;
  assign ostb_fall = port_enabled && !pins_s.out_strobe_n && ostb_q_r;
  assign istb_rise = port_enabled && pins_s.in_strobe_n && !istb_q_r;
  assign istb_fall = port_enabled && !pins_s.in_strobe_n && istb_q_r;

  // Output full flag events
  wire logic out_full_set;
  wire logic out_full_clr;

  assign out_full_set = wr_latch;
  assign out_full_clr = ctl_r.out_clear_edge_mode ? ostb_rise : ostb_fall;

  // Edge-mode capture through the queue
  wire logic cap_push;
  wire logic q_valid;
  wire logic q_ready;
  wire logic [7:0] q_data;
  wire logic q_load;

  assign cap_push = istb_rise && !ctl_r.in_strobe_mode;
  assign q_ready = !ctl_r.in_strobe_mode && !ctl_r.in_buffer_full;
  assign q_load = q_valid && q_ready;

  spp_fifo #(
    .WIDTH(spp_pkg::DATA_W),
    .DEPTH(spp_pkg::FIFO_DEPTH)
  ) u_cap_fifo (
    .clock(clock),
    .reset_n(reset_n),
    .in_valid(cap_push),
    .in_ready(in_fifo_ready),
    .in_data(port_s),
    .out_valid(q_valid),
    .out_ready(q_ready),
    .out_data(q_data)
  );

  // Level-mode transparency
  wire logic transparent;

  assign transparent = ctl_r.in_strobe_mode && !pins_s.in_strobe_n && port_enabled;

  // Input full flag events
  wire logic in_full_set;
  wire logic in_full_clr;

  assign in_full_set = q_load || (ctl_r.in_strobe_mode && istb_fall);
  assign in_full_clr = rd_latch;

  // Writable bit mask for control/status
  wire logic bit_ctl_writable;

  assign bit_ctl_writable = (bit_idx >= spp_pkg::FIRST_RW_BIT);

  // Next control/status
  always_comb begin
    ctl_nxt = ctl_r;
    if (wr_ctl && byte_ctl) begin
      ctl_nxt = (sfr_req.wdata & ~spp_pkg::CTL_RO_MASK) |
                (ctl_r & spp_pkg::CTL_RO_MASK);
    end else if (wr_ctl && bit_ctl_writable) begin
      ctl_nxt[bit_idx] = sfr_req.wdata[0];
    end
    if (out_full_clr) begin
      ctl_nxt.out_buffer_full = 1'b0;
    end
    if (out_full_set) begin
      ctl_nxt.out_buffer_full = 1'b1;
    end
    if (in_full_clr) begin
      ctl_nxt.in_buffer_full = 1'b0;
    end
    if (in_full_set) begin
      ctl_nxt.in_buffer_full = 1'b1;
    end
  end

  // Next port latch
  always_comb begin
    latch_nxt = latch_r;
    if (wr_latch && byte_latch) begin
      latch_nxt = sfr_req.wdata;
    end else if (wr_latch) begin
      latch_nxt[bit_idx] = sfr_req.wdata[0];
    end
  end

  // Next input buffer
  always_comb begin
    ibuf_nxt = ibuf_r;
    if (transparent) begin
      ibuf_nxt = port_s;
    end else if (q_load) begin
      ibuf_nxt = q_data;
    end
  end

  // Register updates
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctl_r <= spp_pkg::CTL_RST;
      latch_r <= spp_pkg::LATCH_RST;
      ibuf_r <= spp_pkg::IBUF_RST;
    end else begin
      ctl_r <= ctl_nxt;
      latch_r <= latch_nxt;
      ibuf_r <= ibuf_nxt;
    end
  end

  // Previous strobe levels for edge detection
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ostb_q_r <= 1'b1;
      istb_q_r <= 1'b1;
    end else begin
      ostb_q_r <= pins_s.out_strobe_n;
      istb_q_r <= pins_s.in_strobe_n;
    end
  end

  // Read data; reading the latch address returns the input buffer
  wire logic [7:0] rd_byte;
  wire logic [7:0] rd_value;

  assign rd_byte = rd_latch ? ibuf_r : ctl_r;
  assign rd_value = sfr_req.bit_op ? {7'h00, rd_byte[bit_idx]} : rd_byte;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sfr_rdata <= 8'h00;
    end else if (rd_latch || rd_ctl) begin
      sfr_rdata <= rd_value;
    end
  end

  // Port drive: source select and driver control
  wire logic [7:0] out_byte;
  wire logic drive_en;
  wire logic [7:0] oe_nxt;

  assign out_byte = (sel_mode && pins_s.sel) ? ctl_r : latch_r;
  assign drive_en = port_enabled && (out_always_mode || !pins_s.out_strobe_n);
  // Quasi-bidirectional: pull low on zeros, ones come from the pull-ups
  assign oe_nxt = drive_en ? ~out_byte : 8'h00;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      port_out <= 8'h00;
      port_oe <= 8'h00;
    end else begin
      port_out <= out_byte;
      port_oe <= oe_nxt;
    end
  end

  // Flag pin functions
  logic out_flag_o;
  logic out_flag_oe;
  logic in_flag_o;
  logic in_flag_oe;

  always_comb begin
    out_flag_o = 1'b0;
    out_flag_oe = 1'b1;
    case (ctl_r.out_side_pin_mode)
      spp_pkg::PIN_DRIVE0: begin
        out_flag_o = 1'b0;
      end
      spp_pkg::PIN_DRIVE1: begin
        out_flag_o = 1'b1;
      end
      spp_pkg::PIN_FLAG: begin
        out_flag_o = ctl_r.out_buffer_full;
      end
      spp_pkg::PIN_INPUT: begin
        out_flag_oe = 1'b0;
      end
      default: begin
        out_flag_oe = 1'b0;
      end
    endcase
  end

  always_comb begin
    in_flag_o = 1'b0;
    in_flag_oe = 1'b1;
    case (ctl_r.in_side_pin_mode)
      spp_pkg::PIN_DRIVE0: begin
        in_flag_o = 1'b0;
      end
      spp_pkg::PIN_DRIVE1: begin
        in_flag_o = 1'b1;
      end
      spp_pkg::PIN_FLAG: begin
        in_flag_o = ctl_r.in_buffer_full;
      end
      spp_pkg::PIN_INPUT: begin
        in_flag_oe = 1'b0;
      end
      default: begin
        in_flag_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      out_side_flag_pin_o <= 1'b0;
      out_side_flag_pin_oe <= 1'b0;
      in_side_flag_pin_o <= 1'b0;
      in_side_flag_pin_oe <= 1'b0;
    end else begin
      out_side_flag_pin_o <= out_flag_o;
      out_side_flag_pin_oe <= out_flag_oe;
      in_side_flag_pin_o <= in_flag_o;
      in_side_flag_pin_oe <= in_flag_oe;
    end
  end

endmodule // spp_port
`default_nettype wire

// file: tb/spp_port_chk.sv
// Port-level assertions for the strobed parallel port
`timescale 1ns/100ps
`default_nettype none
module spp_port_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Bus
  input wire spp_pkg::spp_sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_hit,
  // Port
  input wire logic out_always_mode,
  input wire logic [7:0] port_in,
  input wire logic [7:0] port_out,
  input wire logic [7:0] port_oe,
  input wire logic out_strobe_n,
  input wire logic in_strobe_n,
  // Flag pins
  input wire logic out_side_flag_pin_i,
  input wire logic out_side_flag_pin_o,
  input wire logic out_side_flag_pin_oe,
  input wire logic in_side_flag_pin_i,
  input wire logic in_side_flag_pin_o,
  input wire logic in_side_flag_pin_oe,
  input wire logic in_fifo_ready
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire logic ctl_wr = sfr_req.wr && !sfr_req.bit_op && sfr_req.addr == spp_pkg::ADDR_CTL;
  wire logic drv_off = !out_always_mode && out_strobe_n;

  property p_quasi; port_oe == 8'h00 || port_oe == ~port_out; endproperty
  a_quasi: assert property (p_quasi) else $error("pin pulled low while data one");
  property p_hit;
    sfr_hit == (sfr_req.bit_op ? (sfr_req.addr[7:3] == 5'h1b || sfr_req.addr[7:3] == 5'h1d)
                               : (sfr_req.addr == 8'hd8 || sfr_req.addr == 8'he8));
  endproperty
  a_hit: assert property (p_hit) else $error("address decode wrong");
  property p_rd_hold; !(sfr_req.rd && sfr_hit) |=> $stable(sfr_rdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
  property p_gate;
    (!in_side_flag_pin_oe && in_side_flag_pin_i)[*4] |-> port_oe == 8'h00;
  endproperty
  a_gate: assert property (p_gate) else $error("port driven while disabled");
  property p_drv; drv_off[*4] |-> port_oe == 8'h00; endproperty
  a_drv: assert property (p_drv) else $error("port driven with strobe high");
  property p_sync;
    drv_off[*4] ##1 !out_strobe_n |-> port_oe == 8'h00 ##1 port_oe == 8'h00;
  endproperty
  a_sync: assert property (p_sync) else $error("strobe acted before synchronising");
  property p_a_one;
    ctl_wr && sfr_req.wdata[5:4] == 2'b01 ##1 !sfr_req.wr
      |-> ##1 out_side_flag_pin_oe && out_side_flag_pin_o;
  endproperty
  a_a_one: assert property (p_a_one) else $error("output-side pin not driving one");
  property p_a_sel;
    ctl_wr && sfr_req.wdata[5:4] == 2'b11 ##1 !sfr_req.wr |-> ##1 !out_side_flag_pin_oe;
  endproperty
  a_a_sel: assert property (p_a_sel) else $error("select pin still driven");
  property p_b_zero;
    ctl_wr && sfr_req.wdata[7:6] == 2'b00 ##1 !sfr_req.wr
      |-> ##1 in_side_flag_pin_oe && !in_side_flag_pin_o;
  endproperty
  a_b_zero: assert property (p_b_zero) else $error("input-side pin not driving zero");
endmodule // spp_port_chk
`default_nettype wire

// file: tb/spp_host_model.sv
// Host model: strobes, select, enable and port data
`timescale 1ns/100ps
`default_nettype none
module spp_host_model (
  // Clock
  input wire logic clock,
  // Towards the port
  output var spp_pkg::spp_ctl_pins_t ctl,
  output logic data_oe,
  output logic [7:0] data
);
  initial begin
    ctl = spp_pkg::CTL_PINS_RST;
    data_oe = 1'b0;
    data = 8'h00;
  end
  // Holds all pins n cycles; a slow host passes a larger n
  task automatic drive(input spp_pkg::spp_ctl_pins_t c, input logic oe, input logic [7:0] d,
                       input int n);
    @(posedge clock);
    #1;
    ctl = c;
    data_oe = oe;
    data = d;
    repeat (n) @(posedge clock);
    #1;
  endtask
endmodule // spp_host_model
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the strobed parallel port
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic out_always_mode = 1'b1;
  spp_pkg::spp_sfr_req_t sfr_req = '0;
  spp_pkg::spp_ctl_pins_t hc;
  logic [7:0] sfr_rdata, port_out, port_oe, h_d;
  logic sfr_hit, ao, aoe, bo, boe, in_fifo_ready, h_oe;
  int num_errors = 0;
  int cmp_count = 0;
  // Pull-ups where nobody pulls low
  wire logic [7:0] pins = ~port_oe & (h_oe ? h_d : 8'hff);
  always #5 clock = ~clock;
  spp_host_model host (.clock, .ctl(hc), .data_oe(h_oe), .data(h_d));
  spp_port dut (.clock, .reset_n, .sfr_req, .sfr_rdata, .sfr_hit, .out_always_mode,
    .port_in(pins), .port_out, .port_oe, .out_strobe_n(hc.out_strobe_n),
    .in_strobe_n(hc.in_strobe_n), .out_side_flag_pin_i(aoe ? ao : hc.sel),
    .out_side_flag_pin_o(ao), .out_side_flag_pin_oe(aoe), .in_side_flag_pin_o(bo),
    .in_side_flag_pin_i(boe ? bo : hc.gate), .in_side_flag_pin_oe(boe), .in_fifo_ready);
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic acc(input logic [7:0] a, input logic w, input logic b, input logic [7:0] d);
    @(posedge clock);
    #1 sfr_req = '{addr: a, wr: w, rd: !w, bit_op: b, wdata: d};
    @(posedge clock);
    #1 sfr_req = '0;
    @(posedge clock);
    #1;
  endtask
  task automatic rc(input string n, input logic [7:0] a, input logic [7:0] e);
    acc(a, 1'b0, 1'b0, 8'h00);
    chk(n, sfr_rdata, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic in_pulse(input logic [7:0] d, input logic g);
    host.drive({3'b100, g}, 1'b1, d, 4);
    host.drive({3'b110, g}, 1'b1, d, 4);
    host.drive({3'b110, g}, 1'b0, d, 4);
  endtask
  // Whole run is under 1000 cycles
  initial begin
    #100000;
    num_errors++;
    print_verdict();
  end
  initial begin
    cyc(8);
    reset_n = 1'b1;
    rc("ctl_rst", 8'he8, spp_pkg::CTL_RST);
    acc(8'he8, 1'b1, 1'b0, 8'h03);
    rc("ctl_ro", 8'he8, 8'h00);
    for (int m = 0; m < 3; m++) begin
      acc(8'he8, 1'b1, 1'b0, {m[1:0], m[1:0], 4'h0});
      cyc(3);
      chk("a_flag", {6'h0, aoe, ao}, {7'h1, m == 1});
      chk("b_flag", {6'h0, boe, bo}, {7'h1, m == 1});
    end
    acc(8'he8, 1'b1, 1'b0, 8'h08);
    acc(8'hd8, 1'b1, 1'b0, 8'h55);
    rc("obf_set", 8'he8, 8'h0a);
    chk("oe_always", port_oe, 8'haa);
    out_always_mode = 1'b0;
    cyc(4);
    chk("oe_idle", port_oe, 8'h00);
    host.drive(4'h4, 1'b0, 8'h00, 6);
    chk("oe_strobe", port_oe, 8'haa);
    rc("obf_fall", 8'he8, 8'h0a);
    host.drive(4'hc, 1'b0, 8'h00, 6);
    rc("obf_rise", 8'he8, 8'h08);
    acc(8'he8, 1'b1, 1'b0, 8'h00);
    acc(8'hd8, 1'b1, 1'b0, 8'h55);
    host.drive(4'h4, 1'b0, 8'h00, 6);
    rc("obf_neg", 8'he8, 8'h00);
    host.drive(4'hc, 1'b0, 8'h00, 6);
    in_pulse(8'ha5, 1'b0);
    rc("ibf_set", 8'he8, 8'h01);
    rc("ibuf", 8'hd8, 8'ha5);
    rc("ibf_clr", 8'he8, 8'h00);
    acc(8'he8, 1'b1, 1'b0, 8'h04);
    host.drive(4'h8, 1'b1, 8'h3c, 6);
    rc("ibf_fall", 8'he8, 8'h05);
    rc("transp", 8'hd8, 8'h3c);
    host.drive(4'h8, 1'b1, 8'hc3, 6);
    rc("follow", 8'hd8, 8'hc3);
    host.drive(4'hc, 1'b1, 8'h11, 6);
    rc("hold", 8'hd8, 8'hc3);
    acc(8'he8, 1'b1, 1'b0, 8'h30);
    out_always_mode = 1'b1;
    host.drive(4'he, 1'b0, 8'h00, 6);
    chk("src_ctl", port_out, 8'h30);
    chk("a_in", {7'h0, aoe}, 8'h00);
    host.drive(4'hc, 1'b0, 8'h00, 6);
    chk("src_latch", port_out, 8'h55);
    acc(8'he8, 1'b1, 1'b0, 8'hc0);
    host.drive(4'hd, 1'b0, 8'h00, 6);
    chk("oe_gate", port_oe, 8'h00);
    in_pulse(8'h77, 1'b1);
    rc("ibf_gate", 8'he8, 8'hc0);
    host.drive(4'hc, 1'b0, 8'h00, 6);
    chk("oe_open", port_oe, 8'haa);
    acc(8'heb, 1'b1, 1'b1, 8'h01);
    acc(8'he9, 1'b1, 1'b1, 8'h01);
    acc(8'h90, 1'b1, 1'b0, 8'hff);
    rc("bit_ctl", 8'he8, 8'hc8);
    acc(8'heb, 1'b0, 1'b1, 8'h00);
    chk("bit_rd", sfr_rdata, 8'h01);
    acc(8'hd8, 1'b1, 1'b1, 8'h00);
    cyc(2);
    chk("bit_latch", port_oe, 8'hab);
    acc(8'he8, 1'b1, 1'b0, 8'h00);
    out_always_mode = 1'b0;
    for (int i = 0; i < 10; i++) in_pulse(8'h10 + 8'(i), 1'b0);
    chk("fifo_full", {7'h0, in_fifo_ready}, 8'h00);
    for (int i = 0; i < 9; i++) begin
      rc("drain", 8'hd8, 8'h10 + 8'(i));
      cyc(3);
    end
    chk("fifo_empty", {7'h0, in_fifo_ready}, 8'h01);
    rc("drop", 8'he8, 8'h02);
    acc(8'he8, 1'b1, 1'b0, 8'ha0);
    in_pulse(8'h42, 1'b0);
    chk("a_full", {6'h0, aoe, ao}, 8'h03);
    chk("b_full", {6'h0, boe, bo}, 8'h03);
    host.drive(4'h0, 1'b0, 8'h00, 1);
    reset_n = 1'b0;
    cyc(8);
    reset_n = 1'b1;
    acc(8'hd8, 1'b1, 1'b0, 8'h5a);
    cyc(4);
    chk("plain_oe", port_oe, 8'ha5);
    rc("plain_in", 8'hd8, 8'h5a);
    print_verdict();
  end
endmodule // tb
bind spp_port spp_port_chk u_chk (.clock, .reset_n, .sfr_req, .sfr_rdata, .sfr_hit,
  .out_always_mode, .port_in, .port_out, .port_oe, .out_strobe_n, .in_strobe_n,
  .out_side_flag_pin_i, .out_side_flag_pin_o, .out_side_flag_pin_oe, .in_side_flag_pin_i,
  .in_side_flag_pin_o, .in_side_flag_pin_oe, .in_fifo_ready);
`default_nettype wire
